/* cpsc_pkg.sv */
/*
  package for the clock prescale and sleep control block: register map,
  field positions, reset values, sleep mode encodings and timing counts.
  assumes a 32-bit apb register bus with one register per aligned word.
*/
package cpsc_pkg;

  // register indices (printed offset kept, byte address is four times it)
  localparam logic [7:0] CPSC_IDX_DIVCTL = 8'h61;
  localparam logic [7:0] CPSC_IDX_TRIM = 8'h62;
  localparam logic [7:0] CPSC_IDX_SLEEP = 8'h63;
  localparam logic [7:0] CPSC_IDX_STATUS = 8'h64;
  localparam logic [11:0] CPSC_ADDR_DIVCTL = {2'h0, CPSC_IDX_DIVCTL, 2'h0};
  localparam logic [11:0] CPSC_ADDR_TRIM = {2'h0, CPSC_IDX_TRIM, 2'h0};
  localparam logic [11:0] CPSC_ADDR_SLEEP = {2'h0, CPSC_IDX_SLEEP, 2'h0};
  localparam logic [11:0] CPSC_ADDR_STATUS = {2'h0, CPSC_IDX_STATUS, 2'h0};

  // divide control fields
  localparam int CPSC_DIVCTL_CE_BIT = 7;
  localparam logic [3:0] CPSC_DIV_RESET_PLAIN = 4'h0;
  localparam logic [3:0] CPSC_DIV_RESET_DIV8 = 4'h3;
  localparam logic [3:0] CPSC_DIV_MAX_CODE = 4'h8;

  // sleep control fields
  localparam int CPSC_SLEEP_EN_BIT = 0;
  localparam int CPSC_SLEEP_MODE_LSB = 1;
  localparam int CPSC_SLEEP_BODS_BIT = 4;

  // timing counts in cycles of the undivided clock
  localparam logic [2:0] CPSC_CE_WINDOW_CYC = 3'h4;
  localparam logic [2:0] CPSC_WAKE_HOLD_CYC = 3'h4;

  typedef enum logic [2:0] {
    CPSC_SM_IDLE = 3'h0,
    CPSC_SM_NOISE = 3'h1,
    CPSC_SM_PDOWN = 3'h2,
    CPSC_SM_PSAVE = 3'h3,
    CPSC_SM_STBY = 3'h6,
    CPSC_SM_XSTBY = 3'h7
  } cpsc_mode_t;

  // clock gate bundle handed to the clock tree
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
  } cpsc_gates_t;

  // wake source bundle from the interrupt logic
  typedef struct packed {
    logic ext_irq_level;
    logic ext_irq_edge;
    logic pin_change;
    logic twi_match;
    logic timer2;
    logic nvm_ready;
    logic adc_done;
    logic watchdog;
    logic other_io;
  } cpsc_wake_t;

endpackage

/* cpsc_top.sv */
/*
  clock prescale and sleep control: oscillator trim register, protected
  system clock divider, sleep mode clock gating and wake-up sequencing.
  assumes an apb master on pclk (the undivided master clock), a cpu that
  pulses sleep_instr when it executes its sleep instruction, and wake
  source levels synchronous to pclk.
*/
// Local design decision: the APB register port.
// Functional notes
// - trim loads factory value on every reset
// - trim top bit selects frequency range
// - low seven trim bits tune monotonically
// - divider changes only while enable set
// - enable sets only with other bits zero
// - enable clears after four cycles or write
// - rewriting enable neither restarts nor clears
// - divide by two to the select power
// - reset select follows divide by eight fuse
// - any select loadable after reset
// - divided clock feeds cpu and peripherals
// - divide control layout and read zeros
// - sleep needs enable bit plus instruction
// - three bit sleep mode encoding
// - per mode clock domain gating
// - async timer alive in sleep only in async mode
// - external pins wake when level, edge in idle only
// - cpu held four cycles after startup
// - sleep leaves register file untouched
// - reset during sleep restarts at vector
// - brownout disable only in deep modes
`timescale 1ns/1ps

module cpsc_top
  import cpsc_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = 8'h80
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic initial_div8_fuse,
  input wire logic sleep_instr,
  input wire logic timer2_async,
  input wire logic osc_stable,
  input wire cpsc_wake_t wake_src,
  output logic [7:0] oscillator_trim,
  output logic sys_clk_en,
  output cpsc_gates_t clk_gates,
  output logic cpu_halt,
  output logic asleep,
  output logic osc_restart,
  output logic brownout_detector_off,
  output logic wake_irq
);

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HOLD} cpsc_state_t;

  // decode a register hit for a given byte address
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // register state
  logic [7:0] oscillator_trim_r;
  logic [3:0] divide_select_r;
  logic divide_change_enable_r;
  logic [2:0] ce_cnt_r;
  logic sleep_enable_bit_r;
  logic [2:0] sleep_mode_r;
  logic bods_r;
  logic fuse_loaded_r;
  logic [7:0] div_cnt_r;
  logic sys_clk_en_r;
  cpsc_state_t state_r;
  cpsc_state_t state_nxt;
  logic [2:0] hold_cnt_r;
  logic wake_irq_r;

  // bus access decode
  wire wr_acc = psel & penable & pwrite;
  wire wr_low = wr_acc & pstrb[0];
  wire hit_div = hit(paddr, CPSC_ADDR_DIVCTL);
  wire hit_trim = hit(paddr, CPSC_ADDR_TRIM);
  wire hit_sleep = hit(paddr, CPSC_ADDR_SLEEP);
  wire hit_stat = hit(paddr, CPSC_ADDR_STATUS);
  wire mapped = hit_div | hit_trim | hit_sleep | hit_stat;
  wire [7:0] wbyte = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // divide control write classification
  wire div_wr = wr_low & hit_div;
  wire ce_only_wr = div_wr & (wbyte == 8'h80);
  wire ps_wr = div_wr & ~wbyte[CPSC_DIVCTL_CE_BIT];
  wire ps_ok = ps_wr & divide_change_enable_r;
  wire [3:0] ps_new = wbyte[3:0];

  // oscillator trim, factory value on reset, software may overwrite
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_trim_r <= FACTORY_TRIM;
    end else if (wr_low & hit_trim) begin
      oscillator_trim_r <= wbyte;
    end
  end
  // bit 7 picks range, bits 6:0 tune; passed straight to the oscillator
  assign oscillator_trim = oscillator_trim_r;

  // change enable with a non-restartable four cycle window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divide_change_enable_r <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (divide_change_enable_r) begin
      if (ps_wr || ce_cnt_r == CPSC_CE_WINDOW_CYC - 3'h1) begin
        divide_change_enable_r <= 1'b0;
      end
      ce_cnt_r <= ce_cnt_r + 3'h1;
    end else if (ce_only_wr) begin
      divide_change_enable_r <= 1'b1;
      ce_cnt_r <= 3'h0;
    end
  end

  // divider select; fuse sampled at first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divide_select_r <= CPSC_DIV_RESET_PLAIN;
      fuse_loaded_r <= 1'b0;
    end else if (!fuse_loaded_r) begin
      fuse_loaded_r <= 1'b1;
      divide_select_r <= initial_div8_fuse ? CPSC_DIV_RESET_DIV8 : CPSC_DIV_RESET_PLAIN;
    end else if (ps_ok) begin
      divide_select_r <= ps_new;
    end
  end

  // reserved codes clamp to the largest factor
  wire [3:0] div_eff = (divide_select_r > CPSC_DIV_MAX_CODE) ? CPSC_DIV_MAX_CODE
                                                            : divide_select_r;
  wire [8:0] div_factor = 9'h001 << div_eff;
  wire [7:0] div_last = 8'(div_factor - 9'h001);

  // prescaler: one-cycle enable every 2^n master cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 8'h00;
      sys_clk_en_r <= 1'b0;
    end else if (div_cnt_r >= div_last) begin
      div_cnt_r <= 8'h00;
      sys_clk_en_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      sys_clk_en_r <= 1'b0;
    end
  end
  assign sys_clk_en = sys_clk_en_r;

  // sleep control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_enable_bit_r <= 1'b0;
      sleep_mode_r <= CPSC_SM_IDLE;
      bods_r <= 1'b0;
    end else if (wr_low & hit_sleep) begin
      sleep_enable_bit_r <= wbyte[CPSC_SLEEP_EN_BIT];
      sleep_mode_r <= wbyte[CPSC_SLEEP_MODE_LSB +: 3];
      bods_r <= wbyte[CPSC_SLEEP_BODS_BIT];
    end
  end

  // mode decode
  wire m_idle = sleep_mode_r == CPSC_SM_IDLE;
  wire m_noise = sleep_mode_r == CPSC_SM_NOISE;
  wire m_psave = sleep_mode_r == CPSC_SM_PSAVE;
  wire m_stby = sleep_mode_r == CPSC_SM_STBY;
  wire m_xstby = sleep_mode_r == CPSC_SM_XSTBY;
  wire m_valid = m_idle | m_noise | m_psave | m_stby | m_xstby
               | (sleep_mode_r == CPSC_SM_PDOWN);
  wire m_deep = ~(m_idle | m_noise);

  // wake qualification per mode
  wire w_shared = wake_src.twi_match | wake_src.watchdog
                | wake_src.pin_change | wake_src.ext_irq_level;
  wire w_t2 = wake_src.timer2 & (m_idle | m_psave | m_xstby
                                 | (m_noise & timer2_async));
  wire w_idle = m_idle & (wake_src.ext_irq_edge | wake_src.other_io);
  wire w_mid = (m_idle | m_noise) & (wake_src.nvm_ready | wake_src.adc_done);
  wire wake_any = w_shared | w_t2 | w_idle | w_mid;
  wire enter = sleep_instr & sleep_enable_bit_r & m_valid;

  // sleep sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: if (enter) state_nxt = ST_SLEEP;
      ST_SLEEP: if (wake_any) state_nxt = m_deep ? ST_START : ST_HOLD;
      ST_START: if (osc_stable) state_nxt = ST_HOLD;
      ST_HOLD: if (hold_cnt_r == CPSC_WAKE_HOLD_CYC - 3'h1) state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  // reset aborts sleep; state returns to run and cpu restarts at vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      hold_cnt_r <= 3'h0;
      wake_irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= (state_r == ST_HOLD) ? hold_cnt_r + 3'h1 : 3'h0;
      wake_irq_r <= (state_r == ST_HOLD) && (state_nxt == ST_RUN);
    end
  end

  wire sleeping = state_r == ST_SLEEP;
  wire t2a = timer2_async;

  // clock gating; only clock gates, storage keeps its contents
  always_comb begin
    clk_gates = '1;
    if (state_r != ST_RUN) begin
      clk_gates.cpu = 1'b0;
      clk_gates.flash = 1'b0;
    end
    if (sleeping) begin
      clk_gates.io = m_idle;
      clk_gates.adc = m_idle | m_noise;
      clk_gates.asy = (m_idle | m_noise | m_psave | m_xstby) & t2a;
      clk_gates.main_osc = m_idle | m_noise | m_stby | m_xstby;
      clk_gates.timer_osc = (m_idle | m_noise | m_psave | m_xstby) & t2a;
    end
  end

  assign cpu_halt = state_r != ST_RUN;
  assign asleep = sleeping;
  assign osc_restart = state_r == ST_START;
  assign brownout_detector_off = sleeping & bods_r & m_deep;
  assign wake_irq = wake_irq_r;

  // read mux
  wire [7:0] rd_div = {divide_change_enable_r, 3'h0, divide_select_r};
  wire [7:0] rd_sleep = {3'h0, bods_r, sleep_mode_r, sleep_enable_bit_r};
  wire [7:0] rd_stat = {5'h00, osc_restart, cpu_halt, sleeping};
  wire [7:0] rd_byte = hit_div ? rd_div :
                       hit_trim ? oscillator_trim_r :
                       hit_sleep ? rd_sleep :
                       hit_stat ? rd_stat : 8'h00;
  assign prdata = {24'h000000, rd_byte};

endmodule

/* cpsc_assertions.sv */
/* port checker for cpsc_top, bound to every instance.
   assumes the package register map and a zero wait apb slave. */
`timescale 1ns/1ps
module cpsc_assertions
  import cpsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_instr,
  input wire logic [7:0] oscillator_trim,
  input wire cpsc_gates_t clk_gates,
  input wire logic cpu_halt,
  input wire logic asleep,
  input wire logic brownout_detector_off,
  input wire logic wake_irq
);
  // access phase, map decode and trim write strobe
  wire logic acc = psel && penable;
  wire logic hit = paddr inside {CPSC_ADDR_DIVCTL, CPSC_ADDR_TRIM,
    CPSC_ADDR_SLEEP, CPSC_ADDR_STATUS};
  wire logic twr = acc && pwrite && pstrb[0] && paddr == CPSC_ADDR_TRIM;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_slverr_map: assert property (acc |-> pslverr == !hit)
    else $error("pslverr wrong");
  a_divctl_zeros: assert property (acc && paddr == CPSC_ADDR_DIVCTL
    |-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0) else $error("divctl zeros");
  a_trim_load: assert property (twr |=> oscillator_trim == $past(pwdata[7:0]))
    else $error("trim not loaded");
  a_trim_hold: assert property (!twr |=> $stable(oscillator_trim))
    else $error("trim changed");
  a_sleep_cause: assert property ($rose(asleep) |-> $past(sleep_instr))
    else $error("sleep without instr");
  a_sleep_gates: assert property (asleep |-> cpu_halt && !clk_gates.cpu && !clk_gates.flash)
    else $error("cpu clock in sleep");
  a_run_gates: assert property (!cpu_halt |-> clk_gates == 7'h7F)
    else $error("gates off in run");
  a_wake_hold: assert property ($fell(cpu_halt) |-> wake_irq && $past(cpu_halt, 4))
    else $error("wake hold short");
  a_bod_deep: assert property (brownout_detector_off |-> asleep)
    else $error("bod off awake");
endmodule

bind cpsc_top cpsc_assertions i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .sleep_instr, .oscillator_trim, .clk_gates, .cpu_halt,
  .asleep, .brownout_detector_off, .wake_irq
);

/* cpsc_tb.sv */
/* self-checking bench for cpsc_top over apb.
   assumes the checker is bound and a zero wait slave. */
`timescale 1ns/1ps
module tb
  import cpsc_pkg::*;
;
  localparam logic [7:0] TRIM0 = 8'h80;
  localparam logic [11:0] DIV = CPSC_ADDR_DIVCTL;
  localparam logic [11:0] TRM = CPSC_ADDR_TRIM;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleep_instr = 1'b0, initial_div8_fuse = 1'b1, timer2_async = 1'b1;
  logic osc_stable = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  cpsc_wake_t wake_src = '0;
  cpsc_gates_t clk_gates;
  logic [7:0] oscillator_trim;
  logic pready, pslverr, er, sys_clk_en, cpu_halt, asleep, osc_restart;
  logic brownout_detector_off, wake_irq;
  logic [7:0] sv [8] = '{8'h11, 8'h13, 8'h15, 8'h17, 8'h17, 8'h1D, 8'h1F, 8'h1F};
  logic [6:0] gx [8] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h00, 7'h02, 7'h07, 7'h02};
  int n_fail = 0, cmp_count = 0;

  cpsc_top #(.FACTORY_TRIM(TRIM0)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .initial_div8_fuse, .sleep_instr, .timer2_async, .osc_stable,
    .wake_src, .oscillator_trim, .sys_clk_en, .clk_gates, .cpu_halt, .asleep,
    .osc_restart, .brownout_detector_off, .wake_irq
  );

  // 100 mhz clock
  always #5 pclk = ~pclk;

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask

  // one apb transfer, data and error taken at the pready edge
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rst(input logic f);
    @(posedge pclk);
    presetn <= 1'b0;
    initial_div8_fuse <= f;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task setdiv(input logic [3:0] s);
    xf(1'b1, DIV, 32'h80);
    xf(1'b1, DIV, {28'h0, s});
  endtask

  // sync to pulses, then time one full interval
  task per(input logic [31:0] e);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (sys_clk_en !== 1'b1 && n < 600);
    end
    chk("period", e, n);
  endtask

  task nap(input logic [7:0] v);
    xf(1'b1, CPSC_ADDR_SLEEP, {24'h0, v});
    @(posedge pclk);
    sleep_instr <= 1'b1;
    @(posedge pclk);
    sleep_instr <= 1'b0;
    @(posedge pclk);
  endtask

  task wake(input cpsc_wake_t w);
    wake_src <= w;
    for (int i = 0; i < 40 && wake_irq !== 1'b1; i++) @(posedge pclk);
    chk("wake", 1, wake_irq);
    chk("halt", 0, cpu_halt);
    wake_src <= '0;
  endtask

  task results;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    rst(1'b1);
    xf(1'b0, DIV, '0);
    chk("div rst", 3, rd);
    xf(1'b0, TRM, '0);
    chk("trim rst", TRIM0, rd);
    xf(1'b1, TRM, 32'h7F);
    xf(1'b0, TRM, '0);
    chk("trim", 32'h7F, rd);
    chk("trim pin", 32'h7F, oscillator_trim);
    xf(1'b0, 12'h000, '0);
    chk("slverr", 1, er);
    xf(1'b1, DIV, 32'h81);
    xf(1'b1, DIV, 32'h05);
    xf(1'b0, DIV, '0);
    chk("guard", 3, rd);
    xf(1'b1, DIV, 32'h80);
    xf(1'b0, DIV, '0);
    chk("ce set", 32'h83, rd);
    xf(1'b1, DIV, 32'h80);
    @(posedge pclk);
    xf(1'b1, DIV, 32'h04);
    xf(1'b0, DIV, '0);
    chk("ce edge", 4, rd);
    xf(1'b1, DIV, 32'h80);
    repeat (3) @(posedge pclk);
    xf(1'b1, DIV, 32'h05);
    xf(1'b0, DIV, '0);
    chk("ce late", 4, rd);
    xf(1'b1, DIV, 32'h80);
    xf(1'b1, DIV, 32'h80);
    @(posedge pclk);
    xf(1'b1, DIV, 32'h06);
    xf(1'b0, DIV, '0);
    chk("ce rewrite", 4, rd);
    for (int s = 0; s < 10; s++) begin
      setdiv(s[3:0]);
      xf(1'b0, DIV, '0);
      chk("sel", s, rd);
      per(s > 8 ? 256 : 1 << s);
    end
    for (int i = 0; i < 8; i++) begin
      timer2_async <= (i != 4 && i != 7);
      nap(sv[i]);
      chk("asleep", 1, asleep);
      chk("gates", gx[i], clk_gates);
      chk("bod", i > 1, brownout_detector_off);
      wake(9'h002);
    end
    nap(8'h00);
    chk("no sleep", 0, asleep);
    nap(8'h15);
    wake_src <= 9'h080;
    repeat (10) @(posedge pclk);
    chk("edge", 1, asleep);
    osc_stable <= 1'b0;
    wake_src <= 9'h100;
    repeat (3) @(posedge pclk);
    chk("restart", 1, osc_restart);
    osc_stable <= 1'b1;
    wake(9'h100);
    nap(8'h15);
    rst(1'b0);
    chk("rst halt", 0, cpu_halt);
    xf(1'b0, DIV, '0);
    chk("div rst0", 0, rd);
    xf(1'b0, TRM, '0);
    chk("trim rst0", TRIM0, rd);
    results();
  end

  // watchdog against a hang
  initial begin
    #100us;
    n_fail++;
    results();
  end
endmodule
